/* File: dv/cpu_clock_select_assertions.sv */
// Checker for the CPU clock select block
`timescale 1ns/1ps
`default_nettype none

module cpu_clock_select_assertions (
   // Clock, reset and pins
   input wire logic       clock_in,
   input wire logic       rst_b_in,
   input wire logic       clock_input_pin_in,
   input wire logic       pll_clock_in,
   input wire logic [7:0] system_config_register_in,
   // Outputs watched
   input wire logic       cpu_clock_out,
   input wire logic       osc_fail_irq_out,
   input wire logic       osc_fail_out,
   input wire logic       mode_valid_out,
   input wire logic [2:0] clock_mode_out,
   input wire logic       pll_power_on_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   logic       pin_r;
   logic       pll_r;
   logic [5:0] stall_r;
   wire        bp = mode_valid_out && clock_mode_out[0] && !clock_mode_out[2];
   wire        mon_on = bp && !system_config_register_in[4];
   // Cleared on the raw pin, so it runs ahead of the synchronised count
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pin_r <= 1'b0;
         pll_r <= 1'b0;
         stall_r <= 6'h00;
      end else begin
         pin_r <= clock_input_pin_in;
         pll_r <= pll_clock_in;
         if (!mon_on || pin_r != clock_input_pin_in) stall_r <= 6'h00;
         else if (pll_clock_in && !pll_r && stall_r != 6'h3f)
            stall_r <= stall_r + 6'h01;
      end
   end

   a_irq_pulse: assert property (
      osc_fail_irq_out |=> !osc_fail_irq_out) else $error("irq too long");
   a_irq_on_fail: assert property (
      osc_fail_irq_out |-> $rose(osc_fail_out)) else $error("irq alone");
   a_fail_latched: assert property (
      osc_fail_out |=> osc_fail_out) else $error("failure flag dropped");
   a_no_fail_pll: assert property (
      $rose(osc_fail_out) |-> bp && !$past(system_config_register_in[4]))
      else $error("failure outside monitored mode");
   a_pll_off_dis: assert property (
      mode_valid_out && !osc_fail_out |->
      pll_power_on_out == !(bp && system_config_register_in[4]))
      else $error("pll power wrong");
   a_mode_hold: assert property (
      mode_valid_out |=> mode_valid_out && $stable(clock_mode_out))
      else $error("mode changed after capture");
   a_direct_follow: assert property (
      $past(mode_valid_out, 8) ##0 (clock_mode_out == 3'h3 && !osc_fail_out
      && clock_input_pin_in)[*6] |-> cpu_clock_out)
      else $error("cpu clock not following pin");
   a_fail_bound: assert property (
      stall_r == 6'h14 |-> osc_fail_out) else $error("no failure detected");
   a_fail_not_early: assert property (
      $rose(osc_fail_out) |-> stall_r >= 6'h0e) else $error("early failure");
   a_no_runt_high: assert property (
      $past(mode_valid_out, 8) && $rose(cpu_clock_out) |=>
      cpu_clock_out[*2]) else $error("short cpu clock high phase");
   a_no_runt_low: assert property (
      $past(mode_valid_out, 8) && $fell(cpu_clock_out) |=>
      (!cpu_clock_out)[*2]) else $error("short cpu clock low phase");
endmodule // cpu_clock_select_assertions

bind cpu_clock_select cpu_clock_select_assertions i_chk (.clock_in,
   .rst_b_in, .clock_input_pin_in, .pll_clock_in, .system_config_register_in,
   .cpu_clock_out, .osc_fail_irq_out, .osc_fail_out, .mode_valid_out,
   .clock_mode_out, .pll_power_on_out);

`default_nettype wire

/* File: dv/cpu_clock_select_tb.sv */
// Self-checking bench for the CPU clock select block
`timescale 1ns/1ps
`default_nettype none

module cpu_clock_select_tb;
   logic       clock_in = 1'b0;
   logic       rst_b = 1'b0;
   logic       pll_clk = 1'b0;
   logic       run = 1'b0;
   logic [2:0] mode = 3'h7;
   logic [7:0] cfg = 8'h00;
   wire        pin, cpu_clk, irq, fail, active, valid, bypass, free, power;
   wire        resync;
   wire  [2:0] cmode, idiv, cdiv;
   wire  [6:0] mul;
   wire  [4:0] fac;
   int         errors = 0;
   int         n_tests = 0;
   always #25 clock_in = ~clock_in;
   // Free-running PLL clock, phase unrelated to the sample clock
   always #170 pll_clk = ~pll_clk;
   ext_osc i_osc (.run_in(run), .pin_out(pin));
   cpu_clock_select i_dut (.clock_in(clock_in), .rst_b_in(rst_b),
      .clock_input_pin_in(pin), .pll_clock_in(pll_clk),
      .clock_mode_pins_in(mode), .system_config_register_in(cfg),
      .cpu_clock_out(cpu_clk), .osc_fail_irq_out(irq), .osc_fail_out(fail),
      .monitor_active_out(active), .mode_valid_out(valid),
      .clock_mode_out(cmode), .pll_power_on_out(power),
      .pll_free_run_out(free), .osc_amp_bypass_out(bypass),
      .pll_in_div_out(idiv), .pll_core_mul_out(mul), .pll_core_div_out(cdiv),
      .cpu_factor_out(fac), .pll_resync_out(resync));

   task check(input string name, input logic [17:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task summarize;
      if (errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   task do_reset(input logic [2:0] m, input logic [7:0] c);
      int i;
      @(posedge clock_in);
      rst_b <= 1'b0;
      mode <= m;
      cfg <= c;
      cyc(10);
      rst_b <= 1'b1;
      for (i = 0; i < 20 && valid !== 1'b1; i++) cyc(1);
      check("mode_valid", valid, 1'b1);
      if (valid !== 1'b1) summarize();
   endtask
   task wait_irq;
      int i;
      for (i = 0; i < 300 && irq !== 1'b1; i++) cyc(1);
      check("fail_irq", irq, 1'b1);
      if (irq !== 1'b1) summarize();
      check("fail", fail, 1'b1);
   endtask
   task t_decode;
      int j;
      logic [17:0] e;
      logic b;
      for (j = 0; j < 16; j++) begin
         do_reset(j[2:0], j[3] ? 8'h10 : 8'h00);
         b = !j[2] && j[0];
         case (j[2:0])
            3'h7: e = {3'h4, 7'h40, 3'h4, 5'h04};
            3'h6: e = {3'h4, 7'h30, 3'h4, 5'h03};
            3'h5: e = {3'h4, 7'h40, 3'h2, 5'h08};
            3'h4: e = {3'h4, 7'h28, 3'h2, 5'h05};
            3'h2: e = {3'h2, 7'h28, 3'h2, 5'h0a};
            3'h0: e = {3'h2, 7'h40, 3'h2, 5'h10};
            default: e = {3'h0, 7'h00, 3'h0, 5'h01};
         endcase
         #1;
         check("mode", cmode, j[2:0]);
         check("pll_set", {idiv, mul, cdiv, fac}, e);
         check("bypass", bypass, j[2:0] == 3'h3);
         check("free_run", free, b);
         check("power", power, !(b && j[3]));
         check("active", active, b && !j[3]);
      end
   endtask
   task t_direct;
      int k, np, nc;
      logic a, b;
      do_reset(3'h3, 8'h00);
      @(posedge clock_in);
      mode <= 3'h0;
      run <= 1'b1;
      cyc(60);
      check("mode_hold", cmode, 3'h3);
      check("no_fail", fail, 1'b0);
      @(posedge pin);
      cyc(6);
      check("cpu_follow", cpu_clk, 1'b1);
      run <= 1'b0;
      wait_irq();
      cyc(1);
      check("irq_pulse", irq, 1'b0);
      run <= 1'b1;
      cyc(20);
      np = 0;
      nc = 0;
      for (k = 0; k < 60; k++) begin
         a = pll_clk;
         b = cpu_clk;
         cyc(1);
         np += (pll_clk !== a);
         nc += (cpu_clk !== b);
      end
      check("backup_clk", (np - nc) inside {-1, 0, 1}, 1'b1);
      check("fail_kept", fail, 1'b1);
      check("mon_off", active, 1'b0);
      do_reset(3'h3, 8'h00);
      check("fail_clear", fail, 1'b0);
   endtask
   task t_count(input logic [2:0] m, input int f);
      int r, t;
      logic p, c;
      do_reset(m, 8'h00);
      cyc(20);
      r = 0;
      t = 0;
      p = pin;
      c = cpu_clk;
      repeat (480) begin
         @(posedge clock_in);
         r += (f == 1) ? (pin && !p) : (pin !== p);
         t += (f == 1) ? (cpu_clk !== c) : resync;
         p = pin;
         c = cpu_clk;
      end
      check("rate", (r / f - t) inside {-1, 0, 1}, 1'b1);
      run <= 1'b0;
   endtask
   initial begin
      t_decode();
      t_direct();
      t_count(3'h1, 1);
      wait_irq();
      @(posedge clock_in);
      run <= 1'b1;
      t_count(3'h7, 4);
      cyc(200);
      check("pll_no_fail", fail, 1'b0);
      do_reset(3'h3, 8'h10);
      run <= 1'b0;
      cyc(200);
      check("dis_no_fail", fail, 1'b0);
      check("dis_power", power, 1'b0);
      summarize();
   end
endmodule // cpu_clock_select_tb

`default_nettype wire

/* File: dv/ext_osc.sv */
// Model of the external clock source on the clock input pin
`timescale 1ns/1ps
`default_nettype none

module ext_osc #(
   // Half period; the board keeps it in the legal range
   parameter int HALF_NS = 300
) (
   input  wire logic run_in,
   output var  logic pin_out
);
   // A dead crystal freezes at its last level
   initial pin_out = 1'b0;
   always begin
      #(HALF_NS);
      if (run_in) pin_out = ~pin_out;
   end
endmodule // ext_osc

`default_nettype wire

/* File: inc/clk_sel_map.vh */
// Constants for the CPU clock select and oscillator monitor block
`ifndef CLK_SEL_MAP_VH
`define CLK_SEL_MAP_VH

// Clock mode pin codes
`define MODE_X4        3'h7
`define MODE_X3        3'h6
`define MODE_X8        3'h5
`define MODE_X5        3'h4
`define MODE_DIRECT    3'h3
`define MODE_X10       3'h2
`define MODE_PRESCALE  3'h1
`define MODE_X16       3'h0

// Position of the monitor disable bit in the system config register
`define CFG_MON_DIS_BIT 4

// Monitor overflow: free-running PLL cycles without an input transition
`define MON_OVF_COUNT  5'h10

// Cycles after reset release before the mode pins are captured
`define STRAP_DELAY    2'h3

// Clock source selector states
`define SRC_EXT        2'h0
`define SRC_HOLD       2'h1
`define SRC_BACKUP     2'h2
`define SRC_ARM        2'h3

`endif

/* File: src/cpu_clock_select.v */
// CPU clock source selection with oscillator monitor and backup switch
//
// Summary of operation
// - Monitor enabled after reset; config bit 4 set disables it.
// - Monitor works only in direct drive or prescaler mode.
// - Free-running PLL clock counts up; input clock transitions clear it.
// - Sixteen PLL cycles without input transition means clock failure.
// - On failure switch CPU clock to PLL clock and raise failure request.
// - Backup clock kept until reset, even if input clock returns.
// - Monitor disabled in direct drive or prescaler mode: CPU clock from input only, PLL powered off.
// - Other mode codes enable PLL, CPU clock is input times factor.
// - Codes 7,6,5,4: input /4, multiply/divide 64/4,48/4,64/2,40/2.
// - Codes 2,0: input /2, 40/2 and 64/2; 3 bypass; 1 halves.
// - In PLL mode resynchronise to the input every F transitions.
// - Mode chosen from three pins after reset release, held until next reset.
// - Code 3: PLL free-running for the monitor, amplifier bypassed, CPU clock straight from pin.
// - Code 1: CPU clock is input halved; half period is input period.
`timescale 1ns/1ps
`default_nettype none
`include "clk_sel_map.vh"

module cpu_clock_select (
   // Clock and reset
   input  wire       clock_in,
   input  wire       rst_b_in,
   // Pins and clock sources
   input  wire       clock_input_pin_in,
   input  wire       pll_clock_in,
   input  wire [2:0] clock_mode_pins_in,
   // Configuration from the system config register
   input  wire [7:0] system_config_register_in,
   // CPU clock and status
   output wire       cpu_clock_out,
   output wire       osc_fail_irq_out,
   output wire       osc_fail_out,
   output wire       monitor_active_out,
   output wire       mode_valid_out,
   output wire [2:0] clock_mode_out,
   // PLL control
   output wire       pll_power_on_out,
   output wire       pll_free_run_out,
   output wire       osc_amp_bypass_out,
   output wire [2:0] pll_in_div_out,
   output wire [6:0] pll_core_mul_out,
   output wire [2:0] pll_core_div_out,
   output wire [4:0] cpu_factor_out,
   output wire       pll_resync_out
);

   // Synchroniser taps
   wire       ext_s2;
   wire       ext_s3;
   wire       pll_s2;
   wire       pll_s3;
   wire [2:0] mode_s2;
   wire [2:0] mode_s3;

   // Filtered levels and edges
   reg        ext_lvl_r;
   reg        pll_lvl_r;
   wire       ext_edge;
   wire       ext_rise;
   wire       pll_rise;

   // Mode capture
   reg  [1:0] strap_cnt_r;
   reg        mode_valid_r;
   reg  [2:0] mode_r;

   // Mode decode
   reg        pll_mode;
   reg  [2:0] in_div;
   reg  [6:0] core_mul;
   reg  [2:0] core_div;
   reg  [4:0] factor;

   // Monitor
   wire       mon_en;
   reg  [4:0] mon_cnt_r;
   reg  [4:0] mon_cnt_nxt;
   reg        fail_r;
   reg        irq_r;

   // Clock generation
   reg  [1:0] src_r;
   reg  [1:0] src_nxt;
   reg        presc_r;
   reg        cpu_clk_r;
   reg        cpu_clk_nxt;
   reg        src_lvl;
   reg  [4:0] sync_cnt_r;
   reg        resync_r;

   sync3 #(.W(1)) u_sync_ext (
      .clock_in   (clock_in),
      .rst_b_in   (rst_b_in),
      .async_in   (clock_input_pin_in),
      .stage2_out (ext_s2),
      .stage3_out (ext_s3)
   );

   sync3 #(.W(1)) u_sync_pll (
      .clock_in   (clock_in),
      .rst_b_in   (rst_b_in),
      .async_in   (pll_clock_in),
      .stage2_out (pll_s2),
      .stage3_out (pll_s3)
   );

   sync3 #(.W(3)) u_sync_mode (
      .clock_in   (clock_in),
      .rst_b_in   (rst_b_in),
      .async_in   (clock_mode_pins_in),
      .stage2_out (mode_s2),
      .stage3_out (mode_s3)
   );

   // A level change is accepted only once stages two and three agree
   assign ext_edge = (ext_s2 == ext_s3) && (ext_s3 != ext_lvl_r);
   assign ext_rise = ext_edge && ext_s3;
   assign pll_rise = (pll_s2 == pll_s3) && pll_s3 && !pll_lvl_r;

   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ext_lvl_r <= 1'b0;
         pll_lvl_r <= 1'b0;
      end else begin
         if (ext_s2 == ext_s3) begin
            ext_lvl_r <= ext_s3;
         end
         if (pll_s2 == pll_s3) begin
            pll_lvl_r <= pll_s3;
         end
      end
   end

   // Pins are caught after release, once the synchroniser has settled
   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         strap_cnt_r  <= 2'h0;
         mode_valid_r <= 1'b0;
         mode_r       <= `MODE_X4;
      end else if (!mode_valid_r) begin
         if (strap_cnt_r == `STRAP_DELAY) begin
            if (mode_s2 == mode_s3) begin
               mode_r       <= mode_s3;
               mode_valid_r <= 1'b1;
            end
         end else begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
         end
      end
   end

   always @* begin
      pll_mode = 1'b1;
      in_div   = 3'h4;
      core_mul = 7'h40;
      core_div = 3'h4;
      factor   = 5'h04;
      case (mode_r)
         `MODE_X4: begin
            in_div   = 3'h4;
            core_mul = 7'h40;
            core_div = 3'h4;
            factor   = 5'h04;
         end
         `MODE_X3: begin
            in_div   = 3'h4;
            core_mul = 7'h30;
            core_div = 3'h4;
            factor   = 5'h03;
         end
         `MODE_X8: begin
            in_div   = 3'h4;
            core_mul = 7'h40;
            core_div = 3'h2;
            factor   = 5'h08;
         end
         `MODE_X5: begin
            in_div   = 3'h4;
            core_mul = 7'h28;
            core_div = 3'h2;
            factor   = 5'h05;
         end
         `MODE_X10: begin
            in_div   = 3'h2;
            core_mul = 7'h28;
            core_div = 3'h2;
            factor   = 5'h0a;
         end
         `MODE_X16: begin
            in_div   = 3'h2;
            core_mul = 7'h40;
            core_div = 3'h2;
            factor   = 5'h10;
         end
         default: begin
            pll_mode = 1'b0;
            in_div   = 3'h0;
            core_mul = 7'h00;
            core_div = 3'h0;
            factor   = 5'h01;
         end
      endcase
   end

   // Monitor runs only on bypass modes and while the disable bit is clear
   assign mon_en = mode_valid_r && !pll_mode &&
                   !system_config_register_in[`CFG_MON_DIS_BIT];

   // An input transition clears even when a PLL edge lands in the same cycle
   always @* begin
      mon_cnt_nxt = mon_cnt_r;
      if (!mon_en || fail_r) begin
         mon_cnt_nxt = 5'h00;
      end else if (ext_edge) begin
         mon_cnt_nxt = 5'h00;
      end else if (pll_rise) begin
         mon_cnt_nxt = mon_cnt_r + 5'h01;
      end
   end

   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mon_cnt_r <= 5'h00;
         fail_r    <= 1'b0;
         irq_r     <= 1'b0;
      end else begin
         mon_cnt_r <= mon_cnt_nxt;
         irq_r     <= 1'b0;
         if (!fail_r && mon_cnt_nxt == `MON_OVF_COUNT) begin
            fail_r <= 1'b1;
            irq_r  <= 1'b1;
         end
      end
   end

   // Prescaler: toggles on each input rising edge
   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         presc_r <= 1'b0;
      end else if (ext_rise) begin
         presc_r <= ~presc_r;
      end
   end

   always @* begin
      if (!mode_valid_r) begin
         src_lvl = 1'b0;
      end else if (pll_mode) begin
         src_lvl = pll_lvl_r;
      end else if (mode_r == `MODE_PRESCALE) begin
         src_lvl = presc_r;
      end else begin
         src_lvl = ext_lvl_r;
      end
   end

   // Cut the long stalled phase, then join the backup clock at a falling edge
   always @* begin
      src_nxt     = src_r;
      cpu_clk_nxt = 1'b0;
      case (src_r)
         `SRC_EXT: begin
            cpu_clk_nxt = src_lvl && !fail_r;
            src_nxt     = fail_r ? `SRC_HOLD : src_r;
         end
         `SRC_HOLD: begin
            src_nxt = pll_lvl_r ? `SRC_ARM : `SRC_HOLD;
         end
         `SRC_ARM: begin
            src_nxt = pll_lvl_r ? `SRC_ARM : `SRC_BACKUP;
         end
         default: begin
            cpu_clk_nxt = pll_lvl_r;
         end
      endcase
   end

   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         src_r     <= `SRC_EXT;
         cpu_clk_r <= 1'b0;
      end else begin
         src_r     <= src_nxt;
         cpu_clk_r <= cpu_clk_nxt;
      end
   end

   // Resynchronisation pulse every F input transitions in PLL mode
   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sync_cnt_r <= 5'h00;
         resync_r   <= 1'b0;
      end else begin
         resync_r <= 1'b0;
         if (!mode_valid_r || !pll_mode) begin
            sync_cnt_r <= 5'h00;
         end else if (ext_edge) begin
            if (sync_cnt_r >= factor - 5'h01) begin
               sync_cnt_r <= 5'h00;
               resync_r   <= 1'b1;
            end else begin
               sync_cnt_r <= sync_cnt_r + 5'h01;
            end
         end
      end
   end

   assign cpu_clock_out      = cpu_clk_r;
   assign osc_fail_irq_out   = irq_r;
   assign osc_fail_out       = fail_r;
   assign monitor_active_out = mon_en && !fail_r;
   assign mode_valid_out     = mode_valid_r;
   assign clock_mode_out     = mode_r;
   // PLL stays powered once it is the backup clock source
   assign pll_power_on_out   = mode_valid_r &&
                               (pll_mode || mon_en || fail_r);
   assign pll_free_run_out   = mode_valid_r && !pll_mode;
   assign osc_amp_bypass_out = mode_valid_r &&
                               (mode_r == `MODE_DIRECT);
   assign pll_in_div_out     = in_div;
   assign pll_core_mul_out   = core_mul;
   assign pll_core_div_out   = core_div;
   assign cpu_factor_out     = factor;
   assign pll_resync_out     = resync_r;

endmodule // cpu_clock_select

`default_nettype wire

/* File: src/sync3.v */
// Three-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module sync3 #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         clock_in,
   input  wire         rst_b_in,
   // Asynchronous input
   input  wire [W-1:0] async_in,
   // Second and third stages
   output wire [W-1:0] stage2_out,
   output wire [W-1:0] stage3_out
);

   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;

   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s1_r <= {W{1'b0}};
         s2_r <= {W{1'b0}};
         s3_r <= {W{1'b0}};
      end else begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign stage2_out = s2_r;
   assign stage3_out = s3_r;

endmodule // sync3

`default_nettype wire
